/* File: design/rcgf_pkg.sv */
// package: register map, field positions and constants of the cell insertion / flow nibble block
package rcgf_pkg;
    localparam logic [3:0] OFF_CTRL         = 4'h3;
    localparam logic [3:0] OFF_DATA_BYTE3   = 4'h4;
    localparam logic [3:0] OFF_DATA_BYTE2   = 4'h5;
    localparam logic [3:0] OFF_DATA_BYTE1   = 4'h6;
    localparam logic [3:0] OFF_DATA_BYTE0   = 4'h7;
    localparam int         CTRL_SOC_BIT     = 0;
    localparam int         CTRL_ROOM_BIT    = 1;
    localparam int         CTRL_INS_RST_BIT = 2;
    localparam int         CTRL_CLAV_BIT    = 3;
    localparam int         CTRL_EXT_RST_BIT = 4;
    localparam logic [7:0] CTRL_RESET       = 8'h14;
    localparam int         WORDS_PER_CELL   = 14;
    localparam int         INS_DEPTH        = 16;
    localparam int         NIBBLE_BITS      = 4;
    localparam logic [1:0] GFC_DIV_HALF     = 2'h1;

    typedef struct packed {
        logic        soc;
        logic [31:0] data;
    } rcgf_word_s;
endpackage

/* File: design/rcgf_fifo.sv */
// synchronous valid/ready fifo with parameterised width and depth
module rcgf_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    wr_next;
    logic [AW-1:0]    rd_reg;
    logic [AW-1:0]    rd_next;
    logic [AW:0]      cnt_reg;
    logic [AW:0]      cnt_next;
    logic             push;
    logic             pop;

    always_comb
    begin
        push     = in_valid && in_ready;
        pop      = out_valid && out_ready;
        wr_next  = wr_reg + AW'(push);
        rd_next  = rd_reg + AW'(pop);
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        if (flush)
        begin
            wr_next  = '0;
            rd_next  = '0;
            cnt_next = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            mem[wr_reg] <= in_data;
        end
    end

    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem[rd_reg];
    assign level     = cnt_reg;
endmodule

/* File: design/rcgf_top.sv */
// receive cell insertion register port, extraction readback and serial flow nibble output
module rcgf_top #(
    parameter int DEPTH = rcgf_pkg::INS_DEPTH
) (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    output logic             ins_valid,
    input  wire logic        ins_ready,
    output logic [31:0]      ins_data,
    output logic             ins_soc,
    input  wire logic        ext_valid,
    input  wire logic [31:0] ext_data,
    output logic             ext_ready,
    input  wire logic        cell_hdr_valid,
    input  wire logic [3:0]  cell_hdr_nibble,
    output logic             flow_ctl_nibble_serial_out,
    output logic             flow_ctl_nibble_clock_out,
    output logic             flow_ctl_nibble_msb_marker
);
    localparam int LW = $clog2(DEPTH) + 1;

    logic [7:0]  ctrl_reg;
    logic [7:0]  ctrl_next;
    logic [23:0] hold_reg;
    logic [23:0] hold_next;
    logic [31:0] ext_word_reg;
    logic [31:0] ext_word_next;
    logic [7:0]  rdata_reg;
    logic [7:0]  rdata_next;
    logic        ext_ready_reg;
    logic        ext_ready_next;
    logic        room;
    logic        commit;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic [LW-1:0] level;
    rcgf_pkg::rcgf_word_s fifo_in;
    rcgf_pkg::rcgf_word_s fifo_out;

    // room exists while a whole cell of words still fits
    assign room   = (int'(level) + rcgf_pkg::WORDS_PER_CELL <= DEPTH);
    assign commit = reg_wr && reg_addr == rcgf_pkg::OFF_DATA_BYTE0;
    assign fifo_in = {ctrl_reg[rcgf_pkg::CTRL_SOC_BIT], hold_reg, reg_wdata};

    rcgf_fifo #(
        .WIDTH ($bits(rcgf_pkg::rcgf_word_s)),
        .DEPTH (DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .flush     (!ctrl_reg[rcgf_pkg::CTRL_INS_RST_BIT]),
        .in_data   (fifo_in),
        .in_valid  (commit),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_out_valid),
        .out_ready (ins_ready),
        .level     (level)
    );

    assign ins_valid = fifo_out_valid;
    assign ins_data  = fifo_out.data;
    assign ins_soc   = fifo_out.soc;
    assign ext_ready = ext_ready_reg;
    assign reg_rdata = rdata_reg;

    always_comb
    begin
        ctrl_next      = ctrl_reg;
        hold_next      = hold_reg;
        ext_word_next  = ext_word_reg;
        rdata_next     = rdata_reg;
        ext_ready_next = 1'b0;
        if (reg_wr)
        begin
            case (reg_addr)
                rcgf_pkg::OFF_CTRL:       ctrl_next = {3'h0, reg_wdata[4:0]};
                rcgf_pkg::OFF_DATA_BYTE3: hold_next[23:16] = reg_wdata;
                rcgf_pkg::OFF_DATA_BYTE2: hold_next[15:8] = reg_wdata;
                rcgf_pkg::OFF_DATA_BYTE1: hold_next[7:0] = reg_wdata;
                default:                  hold_next = hold_reg;
            endcase
        end
        ctrl_next[rcgf_pkg::CTRL_ROOM_BIT] = room;
        ctrl_next[rcgf_pkg::CTRL_CLAV_BIT] = ext_valid;
        if (reg_rd)
        begin
            case (reg_addr)
                rcgf_pkg::OFF_CTRL:       rdata_next = ctrl_reg;
                rcgf_pkg::OFF_DATA_BYTE3:
                begin
                    // byte 3 read latches a fresh extraction word and pops it
                    rdata_next     = ext_valid ? ext_data[31:24] : 8'h00;
                    ext_word_next  = ext_data;
                    ext_ready_next = ext_valid && !ext_ready_reg;
                end
                rcgf_pkg::OFF_DATA_BYTE2: rdata_next = ext_word_reg[23:16];
                rcgf_pkg::OFF_DATA_BYTE1: rdata_next = ext_word_reg[15:8];
                rcgf_pkg::OFF_DATA_BYTE0: rdata_next = ext_word_reg[7:0];
                default:                  rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_reg      <= rcgf_pkg::CTRL_RESET;
            hold_reg      <= 24'h000000;
            ext_word_reg  <= 32'h00000000;
            rdata_reg     <= 8'h00;
            ext_ready_reg <= 1'b0;
        end
        else
        begin
            ctrl_reg      <= ctrl_next;
            hold_reg      <= hold_next;
            ext_word_reg  <= ext_word_next;
            rdata_reg     <= rdata_next;
            ext_ready_reg <= ext_ready_next;
        end
    end

    // serial flow nibble port: clock is sys_clk/4, data changes at its rising edge
    typedef enum logic [0:0] { GF_IDLE, GF_SHIFT } rcgf_gfc_e;
    rcgf_gfc_e   gst_reg;
    rcgf_gfc_e   gst_next;
    logic [1:0]  div_reg;
    logic [1:0]  div_next;
    logic [3:0]  pend_reg;
    logic [3:0]  pend_next;
    logic        pend_v_reg;
    logic        pend_v_next;
    logic [3:0]  sh_reg;
    logic [3:0]  sh_next;
    logic [1:0]  bit_reg;
    logic [1:0]  bit_next;
    logic        sclk_reg;
    logic        sclk_next;
    logic        sdo_reg;
    logic        sdo_next;
    logic        msb_reg;
    logic        msb_next;
    logic        rise;
    always_comb
    begin
        div_next    = div_reg + 2'h1;
        rise        = (div_reg == rcgf_pkg::GFC_DIV_HALF);
        sclk_next   = div_next[1];
        gst_next    = gst_reg;
        pend_next   = pend_reg;
        pend_v_next = pend_v_reg;
        sh_next     = sh_reg;
        bit_next    = bit_reg;
        sdo_next    = sdo_reg;
        msb_next    = msb_reg;
        if (rise)
        begin
            case (gst_reg)
                GF_IDLE:
                begin
                    msb_next = 1'b0;
                    if (pend_v_reg)
                    begin
                        sdo_next    = pend_reg[3];
                        msb_next    = 1'b1;
                        sh_next     = {pend_reg[2:0], 1'b0};
                        bit_next    = 2'h1;
                        pend_v_next = 1'b0;
                        gst_next    = GF_SHIFT;
                    end
                end
                GF_SHIFT:
                begin
                    msb_next = 1'b0;
                    sdo_next = sh_reg[3];
                    sh_next  = {sh_reg[2:0], 1'b0};
                    bit_next = bit_reg + 2'h1;
                    if (bit_reg == 2'h3)
                    begin
                        // lsb is out; a pending nibble's msb follows at the next rise
                        gst_next = GF_IDLE;
                    end
                end
                default: gst_next = GF_IDLE;
            endcase
        end
        if (cell_hdr_valid)
        begin
            pend_next   = cell_hdr_nibble;
            pend_v_next = 1'b1;
        end
    end
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            gst_reg    <= GF_IDLE;
            div_reg    <= 2'h0;
            pend_reg   <= 4'h0;
            pend_v_reg <= 1'b0;
            sh_reg     <= 4'h0;
            bit_reg    <= 2'h0;
            sclk_reg   <= 1'b0;
            sdo_reg    <= 1'b0;
            msb_reg    <= 1'b0;
        end
        else
        begin
            gst_reg    <= gst_next;
            div_reg    <= div_next;
            pend_reg   <= pend_next;
            pend_v_reg <= pend_v_next;
            sh_reg     <= sh_next;
            bit_reg    <= bit_next;
            sclk_reg   <= sclk_next;
            sdo_reg    <= sdo_next;
            msb_reg    <= msb_next;
        end
    end
    assign flow_ctl_nibble_serial_out = sdo_reg;
    assign flow_ctl_nibble_clock_out  = sclk_reg;
    assign flow_ctl_nibble_msb_marker = msb_reg;
    property p_commit_soc;
        @(posedge sys_clk) disable iff (!rstn)
        (commit && fifo_in_ready && level == '0 && ctrl_reg[rcgf_pkg::CTRL_INS_RST_BIT])
        |=> (ins_valid && ins_soc == $past(ctrl_reg[rcgf_pkg::CTRL_SOC_BIT]));
    endproperty
    a_commit_soc: assert property (p_commit_soc) else $error("soc tag lost");
    property p_cont;
        @(posedge sys_clk) disable iff (!rstn)
        (commit && !ctrl_reg[rcgf_pkg::CTRL_SOC_BIT] && level == '0
         && ctrl_reg[rcgf_pkg::CTRL_INS_RST_BIT]) |=> !ins_soc;
    endproperty
    a_cont: assert property (p_cont) else $error("continuation tagged as start");
    property p_room;
        @(posedge sys_clk) disable iff (!rstn)
        (int'(level) > DEPTH - rcgf_pkg::WORDS_PER_CELL) |=> !ctrl_reg[rcgf_pkg::CTRL_ROOM_BIT];
    endproperty
    a_room: assert property (p_room) else $error("room shown while full");
    property p_word;
        @(posedge sys_clk) disable iff (!rstn)
        (commit && level == '0 && ctrl_reg[rcgf_pkg::CTRL_INS_RST_BIT])
        |=> ins_data == {$past(hold_reg), $past(reg_wdata)};
    endproperty
    a_word: assert property (p_word) else $error("word assembled wrongly");
    property p_ext;
        @(posedge sys_clk) disable iff (!rstn)
        (reg_rd && reg_addr == rcgf_pkg::OFF_DATA_BYTE2) |=> reg_rdata == $past(ext_word_reg[23:16]);
    endproperty
    a_ext: assert property (p_ext) else $error("read not from extraction word");
    property p_msb_start;
        @(posedge sys_clk) disable iff (!rstn)
        $rose(msb_reg) |-> $rose(sclk_reg);
    endproperty
    a_msb_start: assert property (p_msb_start) else $error("marker off clock edge");
    property p_msb_len;
        @(posedge sys_clk) disable iff (!rstn)
        $rose(msb_reg) |-> msb_reg[*4] ##1 !msb_reg;
    endproperty
    a_msb_len: assert property (p_msb_len) else $error("marker not one bit period");
    property p_data_edge;
        @(posedge sys_clk) disable iff (!rstn)
        $changed(sdo_reg) |-> $rose(sclk_reg);
    endproperty
    a_data_edge: assert property (p_data_edge) else $error("data moved off rising edge");
    property p_nibble;
        @(posedge sys_clk) disable iff (!rstn)
        (rise && gst_reg == GF_IDLE && pend_v_reg && !cell_hdr_valid)
        |=> sdo_reg == $past(pend_reg[3]) ##4 sdo_reg == $past(pend_reg[2], 5);
    endproperty
    a_nibble: assert property (p_nibble) else $error("nibble order wrong");
    c_cell_word: cover property (@(posedge sys_clk) disable iff (!rstn) commit && fifo_in_ready);
    c_full: cover property (@(posedge sys_clk) disable iff (!rstn) !room);
    c_msb: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(msb_reg));
    c_ext_rd: cover property (@(posedge sys_clk) disable iff (!rstn) ext_ready_reg);
endmodule

/* File: verif/rcgf_cpu_model.sv */
// local processor model: byte-wide register writes and reads with strobe handshakes
module rcgf_cpu_model (
    input  wire logic       sys_clk,
    output logic [3:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // one strobe cycle per byte, data line inverted once released
    task automatic wr(input logic [3:0] addr, input logic [7:0] data);
        @(negedge sys_clk);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_wdata = ~data;
    endtask

    // first byte to the top register, the low byte commits the word
    task automatic word(input logic [31:0] w);
        wr(rcgf_pkg::OFF_DATA_BYTE3, w[31:24]);
        wr(rcgf_pkg::OFF_DATA_BYTE2, w[23:16]);
        wr(rcgf_pkg::OFF_DATA_BYTE1, w[15:8]);
        wr(rcgf_pkg::OFF_DATA_BYTE0, w[7:0]);
    endtask

    task automatic rd(input logic [3:0] addr, output logic [7:0] data);
        @(negedge sys_clk);
        reg_addr = addr;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        @(negedge sys_clk);
        data = reg_rdata;
    endtask
endmodule

/* File: verif/rx_atm_cell_insert_and_gfc_out_test.sv */
// self-checking bench: cell word insertion, extraction readback, serial flow nibble port
module rx_atm_cell_insert_and_gfc_out_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 sys_clk = 1'b0;
    logic                 rstn;
    logic [3:0]           reg_addr;
    logic [7:0]           reg_wdata;
    logic                 reg_wr;
    logic                 reg_rd;
    logic [7:0]           reg_rdata;
    logic                 ins_valid;
    logic                 ins_ready;
    logic [31:0]          ins_data;
    logic                 ins_soc;
    logic                 ext_valid;
    logic [31:0]          ext_data;
    logic                 ext_ready;
    logic                 cell_hdr_valid;
    logic [3:0]           cell_hdr_nibble;
    logic                 flow_ctl_nibble_serial_out;
    logic                 flow_ctl_nibble_clock_out;
    logic                 flow_ctl_nibble_msb_marker;
    int                   mismatches = 0;
    int                   num_checks = 0;
    int                   pops = 0;
    int                   bit_left = 0;
    logic                 rise_val;
    logic                 exp_b;
    logic [7:0]           rd_val;
    logic [31:0]          w;
    rcgf_pkg::rcgf_word_s ins_q[$];
    logic                 gfc_q[$];

    always #5 sys_clk = ~sys_clk;

    rcgf_top #(.DEPTH(rcgf_pkg::INS_DEPTH)) rcgf_top_inst (
        .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ins_valid(ins_valid),
        .ins_ready(ins_ready), .ins_data(ins_data), .ins_soc(ins_soc),
        .ext_valid(ext_valid), .ext_data(ext_data), .ext_ready(ext_ready),
        .cell_hdr_valid(cell_hdr_valid), .cell_hdr_nibble(cell_hdr_nibble),
        .flow_ctl_nibble_serial_out(flow_ctl_nibble_serial_out),
        .flow_ctl_nibble_clock_out(flow_ctl_nibble_clock_out),
        .flow_ctl_nibble_msb_marker(flow_ctl_nibble_msb_marker)
    );

    rcgf_cpu_model rcgf_cpu_model_inst (
        .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
    );

    task automatic check(input logic [32:0] seen, input logic [32:0] exp, input string msg);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic rd_check(input logic [3:0] a, input logic [7:0] e);
        rcgf_cpu_model_inst.rd(a, rd_val);
        check({25'h0, rd_val}, {25'h0, e}, "register read");
    endtask

    task automatic conclude();
        $display("mismatches=%0d num_checks=%0d", mismatches, num_checks);
        if (mismatches == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // consumer side: every popped word must be the oldest written one
    always @(posedge sys_clk)
    begin
        if (rstn && ins_valid === 1'b1 && ins_ready === 1'b1)
            check({ins_soc, ins_data}, ins_q.size() ? 33'(ins_q.pop_front()) : 33'bx, "word");
        if (ext_ready === 1'b1)
            pops++;
    end

    always @(posedge flow_ctl_nibble_clock_out)
    begin
        #1;
        rise_val = flow_ctl_nibble_serial_out;
    end

    // serial bits are judged mid-bit, at the falling edge of the port clock
    always @(negedge flow_ctl_nibble_clock_out)
    begin
        if (rstn && bit_left == 0 && flow_ctl_nibble_msb_marker === 1'b1)
            bit_left = 4;
        if (bit_left > 0)
        begin
            exp_b = gfc_q.size() > 0 ? gfc_q.pop_front() : 1'bx;
            check({32'h0, flow_ctl_nibble_msb_marker}, {32'h0, bit_left == 4}, "marker");
            check({32'h0, flow_ctl_nibble_serial_out}, {32'h0, exp_b}, "serial bit");
            check({32'h0, flow_ctl_nibble_serial_out}, {32'h0, rise_val}, "bit moved");
            bit_left--;
        end
    end

    initial
    begin
        rstn = 1'b0;
        ins_ready = 1'b0;
        ext_valid = 1'b0;
        ext_data = 32'h0;
        cell_hdr_valid = 1'b0;
        cell_hdr_nibble = 4'h0;
        void'($urandom(32'h29c4));
        repeat (6) @(negedge sys_clk);
        rstn = 1'b1;
        rd_check(rcgf_pkg::OFF_CTRL, 8'h16);
        rcgf_cpu_model_inst.wr(rcgf_pkg::OFF_CTRL, 8'h15);
        // one full cell, two more words to fill, a last one refused
        for (int k = 0; k < 17; k++)
        begin
            if (k == 1)
                rcgf_cpu_model_inst.wr(rcgf_pkg::OFF_CTRL, 8'h14);
            w = $urandom;
            if (k < 16)
                ins_q.push_back({k == 0, w});
            rcgf_cpu_model_inst.word(w);
            if (k == 13)
                rd_check(rcgf_pkg::OFF_CTRL, 8'h14);
        end
        for (int i = 0; i < 300 && ins_q.size() > 0; i++)
        begin
            @(negedge sys_clk);
            ins_ready = 1'($urandom);
        end
        ins_ready = 1'b1;
        repeat (4) @(negedge sys_clk);
        check(33'(ins_q.size()), 33'h0, "words left");
        // a continuation word into the empty buffer, then dropped by the insertion reset bit
        ins_ready = 1'b0;
        rcgf_cpu_model_inst.word($urandom);
        rcgf_cpu_model_inst.wr(rcgf_pkg::OFF_CTRL, 8'h10);
        rcgf_cpu_model_inst.wr(rcgf_pkg::OFF_CTRL, 8'h14);
        ins_ready = 1'b1;
        rd_check(rcgf_pkg::OFF_CTRL, 8'h16);
        w = $urandom;
        ext_data = w;
        ext_valid = 1'b1;
        rd_check(rcgf_pkg::OFF_DATA_BYTE3, w[31:24]);
        ext_valid = 1'b0;
        ext_data = ~w;
        rd_check(rcgf_pkg::OFF_DATA_BYTE2, w[23:16]);
        rd_check(rcgf_pkg::OFF_DATA_BYTE1, w[15:8]);
        rd_check(rcgf_pkg::OFF_DATA_BYTE0, w[7:0]);
        check(33'(pops), 33'h1, "extraction pops");
        // every nibble value; the second arrives while the first is still shifting
        for (int i = 0; i < 16; i++)
        begin
            @(negedge sys_clk);
            cell_hdr_valid = 1'b1;
            cell_hdr_nibble = 4'(i * 7 + 3);
            for (int b = 3; b >= 0; b--)
                gfc_q.push_back(cell_hdr_nibble[b]);
            @(negedge sys_clk);
            cell_hdr_valid = 1'b0;
            repeat (i == 0 ? 5 : 19) @(negedge sys_clk);
        end
        repeat (40) @(negedge sys_clk);
        check(33'(gfc_q.size()), 33'h0, "serial bits left");
        conclude();
    end

    initial
    begin
        #100000;
        mismatches++;
        conclude();
    end
endmodule
